// *** rtl/zcd_detector.sv ***
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
// How it works
// (RQ1) sample only after commutation and demag; switch group
// (RQ2) hardware compare only on sensing group
// (RQ3) hardware event after filter-count consecutive matches
// (RQ4) capture timer on hardware event when enabled
// (RQ5) simulated event when timer equals compare value
// (RQ6) first of hardware or simulated event wins
// (RQ7) event sets flag; masked flag raises interrupt
// (RQ8) at demag, late compare fires now, overwritten
// (RQ9) protection requires opposite previous sample
// (RQ10) unprotected: current sample equal expected level fires
// (RQ11) protection ignores filter count
// (RQ12) protection unused in sensor or simulated path
// (RQ13) sensor mode picks one of three inputs
// (RQ14) comparator off until clock or direct enabled
// (RQ15) sensor mode disables all demag features
// (RQ16) sensor mode samples at sampling tick anytime
// (RQ17) sensor mode forces zero min off time
// (RQ18) sensor mode keeps filter count active
// (RQ19) software: direct mode, select, then read
// (RQ20) direct mode reads inputs regardless of clock
// (RQ21) polarity, level, select preloaded until commutation
// (RQ22) event starts delay computation
// (RQ23) synchronous logic, cleared on reset
module zcd_detector #(
	parameter int TIMER_W = 8
) (
	input  wire  logic                     clk,
	input  wire  logic                     rstn,
	// register port
	input  wire  zcd_pkg::zcd_bus_req_type bus_req,
	output logic [7:0]                     bus_rdata,
	// motor side
	input  wire  logic                     comparator_in,
	input  wire  logic                     position_in_a,
	input  wire  logic                     position_in_b,
	input  wire  logic                     position_in_c,
	input  wire  logic                     commutation_event,
	input  wire  logic                     demag_event,
	input  wire  logic                     pwm_sample_tick,
	input  wire  logic                     pwm_driven_group,
	input  wire  logic                     fast_sample_tick,
	input  wire  logic [TIMER_W-1:0]       commutation_timer,
	// results
	output logic                           zero_event,
	output logic                           zero_irq,
	output logic                           delay_start,
	output logic [2:0]                     active_output_group,
	output logic                           comparator_enable,
	output logic                           demag_available,
	output logic                           min_off_zero
);

	generate
		if (TIMER_W < 1 || TIMER_W > 8) begin : g_bad_width
			$error("zcd_detector: TIMER_W must be 1..8");
		end
	endgenerate

	// ==========================================================
	// registers
	logic [7:0]          control_reg_a;
	logic [7:0]          control_reg_b;
	logic [7:0]          control_reg_c;
	logic [7:0]          polarity_reg;
	logic [7:0]          phase_state_reg;
	logic [7:0]          zero_filter_reg;
	logic [TIMER_W-1:0]  zero_capture_reg;
	logic [TIMER_W-1:0]  zero_compare_reg;
	logic                zero_event_flag_reg;
	logic                zero_event_mask_reg;
	logic                edge_pol_act_reg;
	logic                level_act_reg;
	logic [1:0]          in_sel_act_reg;
	logic                prev_sample_reg;
	logic                prev_valid_reg;
	logic [3:0]          match_cnt_reg;
	zcd_pkg::zcd_state_type state_reg;
	zcd_pkg::zcd_state_type state_next;

	logic wr_hit;
	logic clock_en;
	logic direct_access;
	logic sensor_mode;
	logic prot_on;
	logic hw_capture_en;
	logic sim_zero_en;
	logic comp_on;
	logic pos_selected;
	logic sample_val;
	logic expected;
	logic sample_strobe;
	logic group_ok;
	logic match;
	logic [4:0] need_cnt;
	logic [4:0] cnt_plus;
	logic zh_fire;
	logic zs_fire;
	logic dcheck_fire;
	logic zero_fire;
	logic flag_clear;

	assign wr_hit        = bus_req.wr;
	assign clock_en      = control_reg_a[zcd_pkg::CRA_CLOCK_EN_BIT];
	assign direct_access = control_reg_a[zcd_pkg::CRA_DIRECT_ACCESS_BIT];
	assign sensor_mode   = control_reg_a[zcd_pkg::CRA_SENSOR_MODE_BIT];
	assign hw_capture_en = control_reg_c[zcd_pkg::CRC_HW_CAPTURE_BIT];
	assign sim_zero_en   = control_reg_c[zcd_pkg::CRC_SIM_ZERO_BIT];

	// ==========================================================
	// register writes
	always_ff @(posedge clk) begin
		if (!rstn) begin // RQ23
			control_reg_a   <= zcd_pkg::REG_RESET_VALUE;
			control_reg_b   <= zcd_pkg::REG_RESET_VALUE;
			control_reg_c   <= zcd_pkg::REG_RESET_VALUE;
			polarity_reg    <= zcd_pkg::REG_RESET_VALUE;
			phase_state_reg <= zcd_pkg::REG_RESET_VALUE;
			zero_filter_reg <= zcd_pkg::REG_RESET_VALUE;
			zero_event_mask_reg <= 1'b0;
		end else if (wr_hit) begin
			unique case (bus_req.addr)
				zcd_pkg::CONTROL_REG_A_ADDR:   control_reg_a   <= bus_req.wdata;
				zcd_pkg::CONTROL_REG_B_ADDR:   control_reg_b   <= bus_req.wdata;
				zcd_pkg::CONTROL_REG_C_ADDR:   control_reg_c   <= bus_req.wdata;
				zcd_pkg::POLARITY_REG_ADDR:    polarity_reg    <= bus_req.wdata;
				zcd_pkg::PHASE_STATE_REG_ADDR: phase_state_reg <= bus_req.wdata;
				zcd_pkg::ZERO_FILTER_REG_ADDR: zero_filter_reg <= bus_req.wdata;
				zcd_pkg::IRQ_MASK_REG_ADDR: begin
					zero_event_mask_reg <= bus_req.wdata[zcd_pkg::MASK_ZERO_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// preloaded settings
	always_ff @(posedge clk) begin
		if (!rstn) begin
			edge_pol_act_reg <= 1'b0;
			level_act_reg    <= 1'b0;
			in_sel_act_reg   <= 2'h0;
		end else if ((!direct_access && commutation_event)
			|| (direct_access && wr_hit
			&& bus_req.addr == zcd_pkg::PHASE_STATE_REG_ADDR)) begin // RQ21
			edge_pol_act_reg <= control_reg_b[zcd_pkg::CRB_EDGE_POLARITY_BIT];
			level_act_reg    <= polarity_reg[zcd_pkg::POL_LEVEL_SELECT_BIT];
			in_sel_act_reg   <= (direct_access && wr_hit) ? bus_req.wdata[1:0]
				: phase_state_reg[1:0];
		end
	end

	// ==========================================================
	// sample path
	assign comp_on = clock_en | direct_access; // RQ14
	assign prot_on = control_reg_a[zcd_pkg::CRA_EDGE_PROTECT_BIT] & ~sensor_mode; // RQ12

	always_comb begin
		unique case (in_sel_act_reg) // RQ13
			2'h0:    pos_selected = position_in_a;
			2'h1:    pos_selected = position_in_b;
			2'h2:    pos_selected = position_in_c;
			default: pos_selected = 1'b0;
		endcase
	end

	assign sample_val = sensor_mode ? pos_selected : comparator_in;
	assign expected   = edge_pol_act_reg ^ level_act_reg;
	assign group_ok   = (pwm_driven_group == polarity_reg[zcd_pkg::POL_SENSING_GROUP_BIT]); // RQ2
	assign sample_strobe = comp_on && (state_reg == zcd_pkg::ZCD_SAMPLING)
		&& (sensor_mode ? fast_sample_tick : (pwm_sample_tick && group_ok)); // RQ16
	assign match    = (sample_val == expected);
	assign need_cnt = (zero_filter_reg[3:0] == 4'h0) ? 5'h01 : {1'b0, zero_filter_reg[3:0]};
	assign cnt_plus = {1'b0, match_cnt_reg} + 5'h01;

	always_comb begin
		zh_fire = 1'b0;
		if (sample_strobe && match) begin
			if (prot_on) begin
				zh_fire = prev_valid_reg && (prev_sample_reg != sample_val); // RQ9 RQ11
			end else begin
				zh_fire = (cnt_plus >= need_cnt); // RQ3 RQ10 RQ18
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			prev_sample_reg <= 1'b0;
			prev_valid_reg  <= 1'b0;
			match_cnt_reg   <= 4'h0;
		end else if (state_reg != zcd_pkg::ZCD_SAMPLING) begin
			prev_valid_reg <= 1'b0;
			match_cnt_reg  <= 4'h0;
		end else if (sample_strobe) begin
			prev_sample_reg <= sample_val;
			prev_valid_reg  <= 1'b1;
			match_cnt_reg   <= !match ? 4'h0
				: (match_cnt_reg == 4'hf) ? 4'hf : cnt_plus[3:0];
		end
	end

	// ==========================================================
	// simulated event and arbitration
	assign dcheck_fire = sim_zero_en && !sensor_mode && (state_reg == zcd_pkg::ZCD_WAIT_D)
		&& demag_event && (zero_compare_reg <= commutation_timer); // RQ8
	assign zs_fire = dcheck_fire || (sim_zero_en && (state_reg == zcd_pkg::ZCD_SAMPLING)
		&& (commutation_timer == zero_compare_reg)); // RQ5
	assign zero_fire = (zh_fire && (hw_capture_en || !sim_zero_en)) || zs_fire; // RQ6

	always_ff @(posedge clk) begin
		if (!rstn) begin
			zero_compare_reg <= '0;
		end else if (dcheck_fire) begin
			zero_compare_reg <= commutation_timer; // RQ8
		end else if (wr_hit && bus_req.addr == zcd_pkg::ZERO_COMPARE_REG_ADDR) begin
			zero_compare_reg <= bus_req.wdata[TIMER_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			zero_capture_reg <= '0;
		end else if (zh_fire && hw_capture_en) begin
			zero_capture_reg <= commutation_timer; // RQ4
		end
	end

	// ==========================================================
	// window state
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			zcd_pkg::ZCD_WAIT_C: begin
				if (commutation_event) begin
					state_next = sensor_mode ? zcd_pkg::ZCD_SAMPLING : zcd_pkg::ZCD_WAIT_D;
				end
			end
			zcd_pkg::ZCD_WAIT_D: begin
				if (dcheck_fire) begin
					state_next = zcd_pkg::ZCD_WAIT_C;
				end else if (demag_event) begin
					state_next = zcd_pkg::ZCD_SAMPLING; // RQ1
				end
			end
			zcd_pkg::ZCD_SAMPLING: begin
				if (zero_fire) begin
					state_next = zcd_pkg::ZCD_WAIT_C;
				end
			end
			default: state_next = zcd_pkg::ZCD_WAIT_C;
		endcase
		if (commutation_event && state_reg != zcd_pkg::ZCD_WAIT_C) begin
			state_next = sensor_mode ? zcd_pkg::ZCD_SAMPLING : zcd_pkg::ZCD_WAIT_D;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= zcd_pkg::ZCD_WAIT_C;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			active_output_group <= 3'h0;
		end else if (state_reg == zcd_pkg::ZCD_WAIT_D && demag_event) begin
			active_output_group <= control_reg_b[2:0]; // RQ1
		end
	end

	// ==========================================================
	// flag, interrupt, outputs
	assign flag_clear = wr_hit && bus_req.addr == zcd_pkg::IRQ_STATUS_REG_ADDR
		&& bus_req.wdata[zcd_pkg::STATUS_ZERO_FLAG_BIT];

	always_ff @(posedge clk) begin
		if (!rstn) begin
			zero_event_flag_reg <= 1'b0;
		end else if (zero_fire) begin
			zero_event_flag_reg <= 1'b1; // RQ7
		end else if (flag_clear) begin
			zero_event_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			zero_irq          <= 1'b0;
			zero_event        <= 1'b0;
			delay_start       <= 1'b0;
			comparator_enable <= 1'b0;
			demag_available   <= 1'b0;
			min_off_zero      <= 1'b0;
		end else begin
			zero_irq          <= zero_event_flag_reg & zero_event_mask_reg; // RQ7
			zero_event        <= zero_fire;
			delay_start       <= zero_fire; // RQ22
			comparator_enable <= comp_on; // RQ14
			demag_available   <= ~sensor_mode; // RQ15
			min_off_zero      <= sensor_mode; // RQ17
		end
	end

	// ==========================================================
	// read port
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bus_rdata <= 8'h00;
		end else if (bus_req.rd) begin
			unique case (bus_req.addr)
				zcd_pkg::CONTROL_REG_A_ADDR:    bus_rdata <= control_reg_a;
				zcd_pkg::CONTROL_REG_B_ADDR:    bus_rdata <= control_reg_b;
				zcd_pkg::CONTROL_REG_C_ADDR:    bus_rdata <= control_reg_c;
				zcd_pkg::POLARITY_REG_ADDR:     bus_rdata <= polarity_reg;
				zcd_pkg::PHASE_STATE_REG_ADDR:  bus_rdata <= phase_state_reg;
				zcd_pkg::ZERO_FILTER_REG_ADDR:  bus_rdata <= zero_filter_reg;
				zcd_pkg::ZERO_CAPTURE_REG_ADDR: bus_rdata <= 8'(zero_capture_reg);
				zcd_pkg::ZERO_COMPARE_REG_ADDR: bus_rdata <= 8'(zero_compare_reg);
				zcd_pkg::IRQ_STATUS_REG_ADDR:   bus_rdata <= {7'h00, zero_event_flag_reg};
				zcd_pkg::IRQ_MASK_REG_ADDR:     bus_rdata <= {7'h00, zero_event_mask_reg};
				zcd_pkg::REFERENCE_REG_ADDR:    bus_rdata <= {7'h00, comp_on & sample_val}; // RQ20
				default:                        bus_rdata <= zcd_pkg::UNMAPPED_READ_VALUE;
			endcase
		end else begin
			bus_rdata <= 8'h00;
		end
	end

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	a_flag_on_event: assert property (zero_fire |=> zero_event_flag_reg) // RQ7
		else $error("zero flag not set after event");
	a_irq_from_flag: assert property (zero_event_flag_reg && zero_event_mask_reg
		|=> zero_irq) // RQ7
		else $error("interrupt not raised");
	a_capture_timer: assert property (zh_fire && hw_capture_en
		|=> zero_capture_reg == $past(commutation_timer)) // RQ4
		else $error("capture value wrong");
	a_comp_disabled: assert property (!clock_en && !direct_access |-> !zh_fire) // RQ14
		else $error("hardware event with comparator off");
	a_protect_edge: assert property (zh_fire && prot_on
		|-> prev_valid_reg && prev_sample_reg != sample_val) // RQ9
		else $error("protected event without edge");
	a_filter_count: assert property (zh_fire && !prot_on |-> cnt_plus >= need_cnt) // RQ3
		else $error("event before filter count");
	a_sim_needs_en: assert property (zs_fire |-> sim_zero_en) // RQ5
		else $error("simulated event while disabled");
	a_dcheck_overwrite: assert property (dcheck_fire
		|=> zero_compare_reg == $past(commutation_timer) && zero_event) // RQ8
		else $error("late compare not overwritten");
	a_group_gate: assert property (zh_fire && !sensor_mode |-> group_ok) // RQ2
		else $error("hardware event on wrong group");
	a_window_open: assert property (zh_fire |-> state_reg == zcd_pkg::ZCD_SAMPLING) // RQ1
		else $error("hardware event outside window");
	a_delay_start: assert property (zero_fire |=> delay_start ##1 !delay_start) // RQ22
		else $error("delay start not a pulse");

	c_hw_event:  cover property (zh_fire && hw_capture_en);
	c_sim_event: cover property (zs_fire && !dcheck_fire);
	c_dcheck:    cover property (dcheck_fire);
	c_sensor_ev: cover property (zh_fire && sensor_mode);

endmodule

// *** shared/zcd_pkg.sv ***
package zcd_pkg;

	// ==========================================================
	// register map (8-bit data, word index per register)
	localparam logic [3:0] CONTROL_REG_A_ADDR     = 4'h0;
	localparam logic [3:0] CONTROL_REG_B_ADDR     = 4'h1;
	localparam logic [3:0] CONTROL_REG_C_ADDR     = 4'h2;
	localparam logic [3:0] POLARITY_REG_ADDR      = 4'h3;
	localparam logic [3:0] PHASE_STATE_REG_ADDR   = 4'h4;
	localparam logic [3:0] ZERO_FILTER_REG_ADDR   = 4'h5;
	localparam logic [3:0] ZERO_CAPTURE_REG_ADDR  = 4'h6;
	localparam logic [3:0] ZERO_COMPARE_REG_ADDR  = 4'h7;
	localparam logic [3:0] IRQ_STATUS_REG_ADDR    = 4'h8;
	localparam logic [3:0] IRQ_MASK_REG_ADDR      = 4'h9;
	localparam logic [3:0] REFERENCE_REG_ADDR     = 4'ha;

	// ==========================================================
	// field positions
	localparam int CRA_CLOCK_EN_BIT        = 0;
	localparam int CRA_DIRECT_ACCESS_BIT   = 1;
	localparam int CRA_SENSOR_MODE_BIT     = 2;
	localparam int CRA_EDGE_PROTECT_BIT    = 3;
	localparam int CRB_EDGE_POLARITY_BIT   = 3;
	localparam int CRC_HW_CAPTURE_BIT      = 0;
	localparam int CRC_SIM_ZERO_BIT        = 1;
	localparam int POL_SENSING_GROUP_BIT   = 0;
	localparam int POL_LEVEL_SELECT_BIT    = 1;
	localparam int STATUS_ZERO_FLAG_BIT    = 0;
	localparam int MASK_ZERO_BIT           = 0;
	localparam int REF_COMP_OUT_BIT        = 0;

	// ==========================================================
	// reset values
	localparam logic [7:0] REG_RESET_VALUE     = 8'h00;
	localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

	// ==========================================================
	// types
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} zcd_bus_req_type;

	typedef enum logic [1:0] {
		ZCD_WAIT_C   = 2'b00,
		ZCD_WAIT_D   = 2'b01,
		ZCD_SAMPLING = 2'b10
	} zcd_state_type;

endpackage

// *** dv/zcd_motor_model.sv ***
`timescale 1ns/1ps
// =============================================
// phase comparator and hall sensors, levels set by the bench
module zcd_motor_model (
	// commands
	input  wire logic       bemf_above,
	input  wire logic [2:0] hall_level,
	// motor pins
	output logic            comparator_in,
	output logic            position_in_a,
	output logic            position_in_b,
	output logic            position_in_c
);
	assign comparator_in = bemf_above;
	assign position_in_a = hall_level[0];
	assign position_in_b = hall_level[1];
	assign position_in_c = hall_level[2];
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
	logic                     clk, rstn, c_ev, d_ev, ptick, grp, ftick, bemf, run_t;
	logic [2:0]               hall, act_grp;
	logic [7:0]               timer, rdata;
	zcd_pkg::zcd_bus_req_type bus_req;
	logic                     cmp_in, pa, pb, pc, zev, zirq, dstart, cmp_en, dem_av, moff;
	int                       miscompares, checks_done, n;

	// =============================================
	// clock, timer, instances
	initial clk = 1'b0;
	always #2.5 clk = ~clk;
	always @(posedge clk) if (run_t) timer <= timer + 8'h01;

	zcd_motor_model i_motor (.bemf_above(bemf), .hall_level(hall), .comparator_in(cmp_in),
		.position_in_a(pa), .position_in_b(pb), .position_in_c(pc));

	zcd_detector #(.TIMER_W(8)) i_dut (.clk(clk), .rstn(rstn), .bus_req(bus_req),
		.bus_rdata(rdata), .comparator_in(cmp_in), .position_in_a(pa), .position_in_b(pb),
		.position_in_c(pc), .commutation_event(c_ev), .demag_event(d_ev),
		.pwm_sample_tick(ptick), .pwm_driven_group(grp), .fast_sample_tick(ftick),
		.commutation_timer(timer), .zero_event(zev), .zero_irq(zirq), .delay_start(dstart),
		.active_output_group(act_grp), .comparator_enable(cmp_en), .demag_available(dem_av),
		.min_off_zero(moff));

	// =============================================
	// shared tasks
	task automatic complete_run();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), rdata, exp);
	endtask

	task automatic cfg(input logic [7:0] cra, crb, crc, pol, filt, cmp, ps);
		wr(zcd_pkg::CONTROL_REG_A_ADDR, cra);
		wr(zcd_pkg::CONTROL_REG_B_ADDR, crb);
		wr(zcd_pkg::CONTROL_REG_C_ADDR, crc);
		wr(zcd_pkg::POLARITY_REG_ADDR, pol);
		wr(zcd_pkg::ZERO_FILTER_REG_ADDR, filt);
		wr(zcd_pkg::ZERO_COMPARE_REG_ADDR, cmp);
		wr(zcd_pkg::PHASE_STATE_REG_ADDR, ps);
	endtask

	// stop the free-running count first, so only this task writes the timer at that edge
	task automatic set_timer(input logic [7:0] v, input logic run);
		@(posedge clk);
		run_t <= 1'b0;
		@(posedge clk);
		timer <= v;
		run_t <= run;
	endtask

	task automatic pulse(input logic is_d);
		@(posedge clk);
		c_ev <= !is_d;
		d_ev <= is_d;
		@(posedge clk);
		c_ev <= 1'b0;
		d_ev <= 1'b0;
	endtask

	// looks for the event pulse over a few cycles starting now
	task automatic watch(input logic exp);
		logic seen;
		seen = 1'b0;
		repeat (4) begin
			#1;
			if (zev === 1'b1) begin
				seen = 1'b1;
				check("delay_start", 8'(dstart), 8'h01);
			end
			@(posedge clk);
		end
		check("zero_event", 8'(seen), 8'(exp));
	endtask

	task automatic tick(input logic fast, input logic exp);
		@(posedge clk);
		ftick <= fast;
		ptick <= !fast;
		@(posedge clk);
		ftick <= 1'b0;
		ptick <= 1'b0;
		watch(exp);
	endtask

	// =============================================
	// scenarios
	task automatic sc_reset();
		#1;
		check("cmp_en", 8'(cmp_en), 8'h00);
		check("demag_av", 8'(dem_av), 8'h01);
		check("min_off", 8'(moff), 8'h00);
		for (int a = 0; a < 12; a++) rdchk(4'(a), zcd_pkg::REG_RESET_VALUE);
	endtask

	task automatic sc_hw();
		set_timer(8'h44, 1'b0);
		cfg(8'h01, 8'h0d, 8'h03, 8'h00, 8'h01, 8'hff, 8'h00);
		wr(zcd_pkg::IRQ_MASK_REG_ADDR, 8'h01);
		bemf <= 1'b1;
		grp <= 1'b1;
		pulse(1'b0);
		pulse(1'b1);
		#1;
		check("act_grp", 8'(act_grp), 8'h05);
		tick(1'b0, 1'b0);
		grp <= 1'b0;
		tick(1'b0, 1'b1);
		check("zero_irq", 8'(zirq), 8'h01);
		rdchk(zcd_pkg::IRQ_STATUS_REG_ADDR, 8'h01);
		rdchk(zcd_pkg::ZERO_CAPTURE_REG_ADDR, 8'h44);
		wr(zcd_pkg::IRQ_STATUS_REG_ADDR, 8'h01);
		repeat (2) @(posedge clk);
		#1;
		check("zero_irq", 8'(zirq), 8'h00);
	endtask

	task automatic sc_filter();
		cfg(8'h01, 8'h0d, 8'h01, 8'h00, 8'h03, 8'hff, 8'h00);
		pulse(1'b0);
		pulse(1'b1);
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b0);
		bemf <= 1'b0;
		tick(1'b0, 1'b0);
		bemf <= 1'b1;
		grp <= 1'b1;
		tick(1'b0, 1'b0);
		grp <= 1'b0;
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b0);
		tick(1'b0, 1'b1);
	endtask

	task automatic sc_protect();
		cfg(8'h09, 8'h05, 8'h01, 8'h03, 8'h03, 8'hff, 8'h00);
		grp <= 1'b1;
		pulse(1'b0);
		pulse(1'b1);
		tick(1'b0, 1'b0);
		bemf <= 1'b0;
		tick(1'b0, 1'b0);
		bemf <= 1'b1;
		tick(1'b0, 1'b1);
	endtask

	task automatic sc_sim();
		bemf <= 1'b0;
		set_timer(8'h30, 1'b0);
		cfg(8'h01, 8'h0d, 8'h02, 8'h00, 8'h01, 8'h10, 8'h00);
		pulse(1'b0);
		pulse(1'b1);
		watch(1'b1);
		rdchk(zcd_pkg::ZERO_COMPARE_REG_ADDR, 8'h30);
		wr(zcd_pkg::ZERO_COMPARE_REG_ADDR, 8'h20);
		set_timer(8'h10, 1'b1);
		pulse(1'b0);
		pulse(1'b1);
		for (n = 0; n < 100 && zev !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		if (n == 100) begin
			miscompares++;
			complete_run();
		end
		check("sim fire", 8'(timer > 8'h20 && timer < 8'h24), 8'h01);
		set_timer(8'h00, 1'b0);
	endtask

	task automatic sc_sensor();
		cfg(8'h05, 8'h08, 8'h00, 8'h00, 8'h02, 8'hff, 8'h02);
		hall <= 3'b100;
		pulse(1'b0);
		#1;
		check("demag_av", 8'(dem_av), 8'h00);
		check("min_off", 8'(moff), 8'h01);
		wr(zcd_pkg::PHASE_STATE_REG_ADDR, 8'h00);
		tick(1'b1, 1'b0);
		tick(1'b1, 1'b1);
	endtask

	task automatic sc_direct();
		wr(zcd_pkg::CONTROL_REG_A_ADDR, 8'h06);
		hall <= 3'b010;
		wr(zcd_pkg::PHASE_STATE_REG_ADDR, 8'h01);
		rdchk(zcd_pkg::REFERENCE_REG_ADDR, 8'h01);
		check("cmp_en", 8'(cmp_en), 8'h01);
		hall <= 3'b101;
		rdchk(zcd_pkg::REFERENCE_REG_ADDR, 8'h00);
	endtask

	// =============================================
	// main sequence
	initial begin
		{rstn, c_ev, d_ev, ptick, grp, ftick, bemf, run_t} = '0;
		hall = 3'b111;
		timer = 8'h00;
		bus_req = '0;
		miscompares = 0;
		checks_done = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		sc_reset();
		sc_hw();
		sc_filter();
		sc_protect();
		sc_sim();
		sc_sensor();
		sc_direct();
		complete_run();
	end
endmodule
